/* File: hdl/dhli_pkg.sv */
package dhli_pkg;

  // ----------------------------------------------------------------
  // register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] DHLI_CTRL_OFS = 8'h00;
  localparam logic [7:0] DHLI_DATA_OFS = 8'h04;
  localparam logic [7:0] DHLI_CMD_OFS = 8'h08;
  localparam logic [7:0] DHLI_STAT_OFS = 8'h0c;
  localparam logic [7:0] DHLI_WORD_OFS = 8'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int DHLI_CTRL_MODE_LSB = 0;
  localparam int DHLI_CTRL_ORDER_BIT = 2;
  localparam int DHLI_CTRL_BIPOLAR_BIT = 3;
  localparam int DHLI_CTRL_HOLD_LSB = 8;
  localparam logic [31:0] DHLI_CTRL_RST = 32'h0000_0400;
  localparam int DHLI_STAT_BUSY_BIT = 0;
  localparam int DHLI_STAT_STATE_LSB = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DHLI_CLK_NS = 100;
  localparam int DHLI_SER_BIT_NS = 1000;
  localparam int DHLI_SER_HALF_CYC = (DHLI_SER_BIT_NS / 2 + DHLI_CLK_NS - 1) / DHLI_CLK_NS;
  localparam int DHLI_WORD_BITS = 16;
  localparam int DHLI_BYTE_BITS = 8;

  // ----------------------------------------------------------------
  // modes, commands, bus addresses
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DHLI_MODE_SERIAL = 2'h0,
    DHLI_MODE_BYTE = 2'h1
  } dhli_mode_t;

  typedef enum logic [2:0] {
    DHLI_CMD_SEND = 3'h1,
    DHLI_CMD_LOW = 3'h2,
    DHLI_CMD_HIGH = 3'h3,
    DHLI_CMD_UPDATE = 3'h4,
    DHLI_CMD_CLEAR = 3'h5
  } dhli_cmd_t;

  typedef enum logic [2:0] {
    DHLI_BUS_LOW = 3'h0,
    DHLI_BUS_HIGH = 3'h1,
    DHLI_BUS_UPD = 3'h2,
    DHLI_BUS_CLR_UNI = 3'h4,
    DHLI_BUS_CLR_BI = 3'h5
  } dhli_bus_addr_t;

  // pins toward the converter
  typedef struct packed {
    logic serial_mode_select_n;
    logic dac_latch_load;
    logic high_byte_enable_n;
    logic low_byte_enable_n;
    logic async_zero_clear_n;
    logic cs_strobe_n;
    logic bit_order_select;
    logic [7:0] data_pins;
  } dhli_pins_t;

endpackage : dhli_pkg

/* File: hdl/dhli_shifter.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// serial shifter: strobe-clocked, msb first, data valid at rising edge
// ------------------------------------------------------------------
module dhli_shifter
  import dhli_pkg::*;
#(
  parameter int HALF_CYC = DHLI_SER_HALF_CYC,
  parameter int NBITS = DHLI_WORD_BITS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic [NBITS-1:0] word,
  output logic done,
  // pins
  output logic strobe_n,
  output logic sdata
);

  logic [NBITS-1:0] sh_r;
  logic [$clog2(NBITS+1)-1:0] cnt_r;
  logic [7:0] tick_r;
  logic act_r;

  // strobe low half: present bit; high half: device samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= '0;
      cnt_r <= '0;
      tick_r <= '0;
      act_r <= 1'b0;
      strobe_n <= 1'b1;
      sdata <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!act_r) begin
        if (start) begin
          act_r <= 1'b1;
          sh_r <= word;
          cnt_r <= '0;
          tick_r <= '0;
          strobe_n <= 1'b0;
          sdata <= word[NBITS-1];
        end
      end else if (tick_r == 8'(HALF_CYC - 1)) begin
        tick_r <= '0;
        if (!strobe_n) begin
          strobe_n <= 1'b1;
        end else if (cnt_r == ($clog2(NBITS+1))'(NBITS - 1)) begin
          act_r <= 1'b0;
          done <= 1'b1;
        end else begin
          strobe_n <= 1'b0;
          cnt_r <= cnt_r + 1'b1;
          sh_r <= {sh_r[NBITS-2:0], 1'b0};
          sdata <= sh_r[NBITS-2];
        end
      end else begin
        tick_r <= tick_r + 1'b1;
      end
    end
  end

endmodule // dhli_shifter
`default_nettype wire

/* File: hdl/dhli_bus_writer.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// byte-bus write cycle: address, then request and write strobes together
// ------------------------------------------------------------------
module dhli_bus_writer
  import dhli_pkg::*;
#(
  parameter int STROBE_CYC = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic [2:0] addr,
  output logic done,
  // strobe level, the same for every address; the host decodes it
  output logic strobe
);

  logic [3:0] cnt_r;
  logic [1:0] ph_r;

  // phase 1: setup, phase 2: strobe, phase 3: release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      ph_r <= '0;
      strobe <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (ph_r)
        2'h0: if (start) ph_r <= 2'h1;
        2'h1: begin
          ph_r <= 2'h2;
          strobe <= 1'b1;
          cnt_r <= '0;
        end
        2'h2: if (cnt_r == 4'(STROBE_CYC - 1)) begin
          strobe <= 1'b0;
          ph_r <= 2'h3;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
        2'h3: begin
          ph_r <= 2'h0;
          done <= 1'b1;
        end
      endcase
    end
  end

endmodule // dhli_bus_writer
`default_nettype wire

/* File: hdl/dhli_host.sv */
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dhli_host
  import dhli_pkg::*;
#(
  parameter int HALF_CYC = DHLI_SER_HALF_CYC,
  parameter int STROBE_CYC = 2,
  parameter int LOAD_HIGH_CYC = 2 * DHLI_SER_HALF_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter pins
  output dhli_pins_t dac_pins
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_BUS,
    ST_LOAD_HI,
    ST_CLR_SETUP,
    ST_DONE
  } dhli_state_t;

  dhli_state_t state_r;
  logic [31:0] ctrl_r;
  logic [15:0] data_r;
  logic [15:0] word_r;
  logic [2:0] cmd_r;
  logic go_r;
  logic sh_start_r;
  logic bw_start_r;
  logic [2:0] bw_addr_r;
  logic [7:0] hold_r;
  logic sh_done;
  logic sh_strobe_n;
  logic sh_data;
  logic bw_done;
  logic bw_strobe;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic busy;

  assign busy = (state_r != ST_IDLE);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign mapped = (paddr == DHLI_CTRL_OFS) || (paddr == DHLI_DATA_OFS) || (paddr == DHLI_CMD_OFS)
    || (paddr == DHLI_STAT_OFS) || (paddr == DHLI_WORD_OFS);

  // ----------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped or busy command
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || (pwrite && busy && paddr == DHLI_CMD_OFS));
      if (rd_en) begin
        unique case (paddr)
          DHLI_CTRL_OFS: prdata <= ctrl_r;
          DHLI_DATA_OFS: prdata <= {16'h0000, data_r};
          DHLI_CMD_OFS: prdata <= {29'h0, cmd_r};
          DHLI_STAT_OFS: prdata <= {25'h0, 3'(state_r), 3'h0, busy};
          DHLI_WORD_OFS: prdata <= {16'h0000, word_r};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // control and data registers; a write lands at the access edge, where pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= DHLI_CTRL_RST;
      data_r <= '0;
    end else if (wr_en && pready && !busy) begin
      if (paddr == DHLI_CTRL_OFS) ctrl_r <= {16'h0, pwdata[15:8], 4'h0, pwdata[3:0]};
      if (paddr == DHLI_DATA_OFS) data_r <= pwdata[15:0];
    end
  end

  // command register: a write starts one operation when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= '0;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (wr_en && pready && !busy && paddr == DHLI_CMD_OFS) begin
        cmd_r <= pwdata[2:0];
        go_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      word_r <= '0;
      sh_start_r <= 1'b0;
      bw_start_r <= 1'b0;
      bw_addr_r <= '0;
      hold_r <= '0;
      dac_pins <= '{serial_mode_select_n: 1'b1, dac_latch_load: 1'b1, high_byte_enable_n: 1'b1,
                    low_byte_enable_n: 1'b1, async_zero_clear_n: 1'b1, cs_strobe_n: 1'b1,
                    bit_order_select: 1'b1, data_pins: 8'h00};
    end else begin
      sh_start_r <= 1'b0;
      bw_start_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          dac_pins.serial_mode_select_n <= (ctrl_r[DHLI_CTRL_MODE_LSB +: 2] != DHLI_MODE_SERIAL);
          dac_pins.bit_order_select <= ~ctrl_r[DHLI_CTRL_ORDER_BIT];
          // byte mode rests with load low, so byte writes wait for the update
          if (ctrl_r[DHLI_CTRL_MODE_LSB +: 2] != DHLI_MODE_SERIAL) dac_pins.dac_latch_load <= 1'b0;
          if (go_r) begin
            unique case (cmd_r)
              DHLI_CMD_SEND: begin
                dac_pins.dac_latch_load <= 1'b0;
                sh_start_r <= 1'b1;
                state_r <= ST_SHIFT;
              end
              DHLI_CMD_LOW, DHLI_CMD_HIGH: begin
                bw_addr_r <= (cmd_r == DHLI_CMD_LOW) ? DHLI_BUS_LOW : DHLI_BUS_HIGH;
                dac_pins.data_pins <= (cmd_r == DHLI_CMD_LOW) ? data_r[7:0] : data_r[15:8];
                bw_start_r <= 1'b1;
                state_r <= ST_BUS;
              end
              DHLI_CMD_UPDATE: begin
                bw_addr_r <= DHLI_BUS_UPD;
                bw_start_r <= 1'b1;
                state_r <= ST_BUS;
              end
              DHLI_CMD_CLEAR: begin
                // select level of the low-byte enable before the clear strobe;
                // a low enable also opens the low byte, so it is given the data low byte again
                dac_pins.data_pins <= data_r[7:0];
                dac_pins.low_byte_enable_n <= ctrl_r[DHLI_CTRL_BIPOLAR_BIT];
                bw_addr_r <= ctrl_r[DHLI_CTRL_BIPOLAR_BIT] ? DHLI_BUS_CLR_BI : DHLI_BUS_CLR_UNI;
                state_r <= ST_CLR_SETUP;
              end
              default: state_r <= ST_DONE;
            endcase
          end
        end
        ST_CLR_SETUP: begin
          bw_start_r <= 1'b1;
          state_r <= ST_BUS;
        end
        ST_SHIFT: begin
          dac_pins.cs_strobe_n <= sh_strobe_n;
          dac_pins.data_pins[0] <= sh_data;
          if (sh_done) begin
            word_r <= data_r;
            hold_r <= '0;
            dac_pins.dac_latch_load <= 1'b1;
            state_r <= ST_LOAD_HI;
          end
        end
        ST_LOAD_HI: begin
          // keep load high a strobe cycle before next word may start
          if (hold_r == 8'(LOAD_HIGH_CYC - 1)) state_r <= ST_DONE;
          else hold_r <= hold_r + 1'b1;
        end
        ST_BUS: begin
          // byte lsb picks the enable, upper bits pick the function
          unique case (bw_addr_r[2:1])
            2'h0: begin
              dac_pins.low_byte_enable_n <= !(bw_strobe && !bw_addr_r[0]);
              dac_pins.high_byte_enable_n <= !(bw_strobe && bw_addr_r[0]);
            end
            2'h1: dac_pins.dac_latch_load <= bw_strobe;
            default: dac_pins.async_zero_clear_n <= !bw_strobe;
          endcase
          if (bw_done) begin
            if (bw_addr_r[2:1] == 2'h1) word_r <= data_r;
            // release the low-byte enable that a clear may have left low
            dac_pins.low_byte_enable_n <= 1'b1;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // engines
  // ----------------------------------------------------------------
  dhli_shifter #(
    .HALF_CYC(HALF_CYC),
    .NBITS(DHLI_WORD_BITS)
  ) u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .start(sh_start_r),
    .word(data_r),
    .done(sh_done),
    .strobe_n(sh_strobe_n),
    .sdata(sh_data)
  );

  dhli_bus_writer #(
    .STROBE_CYC(STROBE_CYC)
  ) u_bus_writer (
    .pclk(pclk),
    .presetn(presetn),
    .start(bw_start_r),
    .addr(bw_addr_r),
    .done(bw_done),
    .strobe(bw_strobe)
  );

endmodule // dhli_host
`default_nettype wire

/* File: tb/dhli_host_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// port checker for the host block
// ----------------------------------------------------------------
module dhli_host_checker
  import dhli_pkg::*;
#(
  parameter int HALF_CYC = 5
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // converter pins
  input wire dhli_pins_t dac_pins
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answer timing and error reporting
  setup_ready_a: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no ready in the access phase");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
    else $error("unmapped access not refused");
  // serial strobe, load line and byte enables
  load_low_shift_a: assert property (!dac_pins.cs_strobe_n |-> !dac_pins.dac_latch_load)
    else $error("strobe active while load line high");
  select_low_a: assert property (!dac_pins.cs_strobe_n |-> !dac_pins.serial_mode_select_n)
    else $error("strobe active outside serial mode");
  strobe_low_a: assert property ($fell(dac_pins.cs_strobe_n) |-> (!dac_pins.cs_strobe_n) [*5] ##1 dac_pins.cs_strobe_n)
    else $error("strobe low half period wrong");
  data_stable_a: assert property ($rose(dac_pins.cs_strobe_n) |-> $stable(dac_pins.data_pins[0]))
    else $error("serial data moved at strobe rise");
  load_hold_a: assert property ($rose(dac_pins.dac_latch_load) && !dac_pins.serial_mode_select_n
    |-> dac_pins.dac_latch_load [*8])
    else $error("load high time too short");
  byte_excl_a: assert property (!dac_pins.high_byte_enable_n |-> dac_pins.low_byte_enable_n)
    else $error("both byte enables active");
endmodule // dhli_host_checker

bind dhli_host dhli_host_checker #(.HALF_CYC(HALF_CYC)) dhli_host_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dac_pins(dac_pins));

`default_nettype wire

/* File: tb/dhli_dac_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// behavioural converter: first rank latch and dac latch
// ----------------------------------------------------------------
module dhli_dac_model
  import dhli_pkg::*;
#(
  parameter logic [15:0] BIPOLAR_ZERO = 16'h8000
) (
  // pins from the host
  input wire dhli_pins_t pins,
  // latch contents
  output logic [15:0] first_rank,
  output logic [15:0] dac_word
);
  initial first_rank = 16'h0000;
  initial dac_word = 16'h0000;

  // serial shift on strobe rise, order picked by pin one
  always @(posedge pins.cs_strobe_n) begin
    if (!pins.serial_mode_select_n) begin
      if (pins.bit_order_select) begin
        first_rank <= {first_rank[14:0], pins.data_pins[0]};
      end else begin
        first_rank <= {pins.data_pins[0], first_rank[15:1]};
      end
    end
  end

  // byte enables are level latches; last level seen at release
  always @(posedge pins.low_byte_enable_n) begin
    if (pins.serial_mode_select_n) begin
      first_rank[7:0] <= pins.data_pins;
    end
  end
  always @(posedge pins.high_byte_enable_n) begin
    if (pins.serial_mode_select_n) begin
      first_rank[15:8] <= pins.data_pins;
    end
  end

  // load is a level: while high the dac latch follows the first rank; data pins not looked at
  always @(pins.dac_latch_load or first_rank) begin
    if (pins.dac_latch_load) begin
      dac_word <= first_rank;
    end
  end

  // clear touches the dac latch only
  always @(negedge pins.async_zero_clear_n) begin
    dac_word <= pins.low_byte_enable_n ? BIPOLAR_ZERO : 16'h0000;
  end
endmodule // dhli_dac_model

`default_nettype wire

/* File: tb/dhli_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// testbench for the host block
// ----------------------------------------------------------------
module dhli_host_tb;
  import dhli_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  dhli_pins_t dac_pins;
  logic [15:0] first_rank, dac_word;
  int fail_count, checked;

  dhli_host dhli_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dac_pins(dac_pins));
  dhli_dac_model dhli_dac_model_inst (.pins(dac_pins), .first_rank(first_rank), .dac_word(dac_word));

  // clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one apb transfer, waits for ready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll busy until idle
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, DHLI_STAT_OFS, 32'h0);
      n++;
    end while (rd[DHLI_STAT_BUSY_BIT] !== 1'b0 && n < 300);
    if (n >= 300) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic cmd(input logic [31:0] c);
    apb(1'b1, DHLI_CMD_OFS, c);
    wait_idle();
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset value and unmapped refusal
    apb(1'b0, DHLI_CTRL_OFS, 32'h0);
    check(rd, DHLI_CTRL_RST);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test reset done");
    // serial word, upper byte first, refusal while busy
    apb(1'b1, DHLI_CTRL_OFS, DHLI_CTRL_RST);
    apb(1'b1, DHLI_DATA_OFS, 32'h0000a53c);
    apb(1'b1, DHLI_CMD_OFS, 32'h1);
    apb(1'b1, DHLI_CMD_OFS, 32'h1);
    check({31'h0, err}, 32'h1);
    wait_idle();
    check({16'h0, first_rank}, 32'h0000a53c);
    check({16'h0, dac_word}, 32'h0000a53c);
    apb(1'b0, DHLI_WORD_OFS, 32'h0);
    check(rd & 32'hffff, 32'h0000a53c);
    $display("test serial done");
    // byte writes, output held until update
    apb(1'b1, DHLI_CTRL_OFS, DHLI_CTRL_RST | 32'h1);
    apb(1'b1, DHLI_DATA_OFS, 32'h00001234);
    cmd(32'h2);
    cmd(32'h3);
    check({16'h0, first_rank}, 32'h00001234);
    check({16'h0, dac_word}, 32'h0000a53c);
    cmd(32'h4);
    check({16'h0, dac_word}, 32'h00001234);
    $display("test byte done");
    // clears, then reload from the first rank
    cmd(32'h5);
    check({16'h0, dac_word}, 32'h00000000);
    check({16'h0, first_rank}, 32'h00001234);
    apb(1'b1, DHLI_CTRL_OFS, DHLI_CTRL_RST | 32'h9);
    cmd(32'h5);
    check({16'h0, dac_word}, 32'h00008000);
    cmd(32'h4);
    check({16'h0, dac_word}, 32'h00001234);
    $display("test clear done");
    print_verdict();
  end
endmodule // dhli_host_tb

`default_nettype wire
